// *** wtc_cache.sv ***
// Write-through cache controller between a 32-bit processor bus and main memory.
// Assumes mode and policy inputs are static after reset and memory answers with a one-cycle ack.
// Summary of operation
// - Direct-mapped: each block has one candidate line, so one tag compare.
// - Direct-mapped split: 14-bit line index, 2-bit byte select, 8-bit tag.
// - Upper eight address bits only decide whether the access is cacheable.
// - Compare only stored tag at the indexed line with request tag bits.
// - Tag match serves the read from cache without a memory access.
// - Mismatch fetches aligned 4-byte block, fills line and tag, returns data.
// - Two-way mode halves lines; 13-bit set index, freed bit joins tag.
// - Two-way mode compares both ways and returns data from the way that hit.
// - Two-way refill may go to either way; a way is picked each fetch.
// - LRU mode keeps per-set bit naming victim, updated on every cached hit and refill.
// - Sequential or random victim choice may replace LRU.
// - Fully associative: 128 entries hold full block address, all compared.
// - Every write goes to main memory right after the cache update.
// - Refill overwrites a line without copying it back.
// - A read miss on any byte copies the whole aligned block.
`timescale 1ns/100ps
`default_nettype none
module wtc_cache #(
  parameter logic [wtc_pkg::REGION_W-1:0] CACHE_REGION = wtc_pkg::REGION_DEF
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [1:0]                  cfg_mode,
  input  wire logic [1:0]                  cfg_policy,
  input  wire logic                        cpu_req,
  input  wire logic                        cpu_we,
  input  wire logic [wtc_pkg::ADDR_W-1:0]  cpu_addr,
  input  wire logic [wtc_pkg::BE_W-1:0]    cpu_be,
  input  wire logic [wtc_pkg::DATA_W-1:0]  cpu_wdata,
  output logic                             cpu_ready,
  output logic                             cpu_hit,
  output logic [wtc_pkg::DATA_W-1:0]       cpu_rdata,
  output logic                             mem_req,
  output logic                             mem_we,
  output logic [wtc_pkg::ADDR_W-1:0]       mem_addr,
  output logic [wtc_pkg::BE_W-1:0]         mem_be,
  output logic [wtc_pkg::DATA_W-1:0]       mem_wdata,
  input  wire logic                        mem_ack,
  input  wire logic [wtc_pkg::DATA_W-1:0]  mem_rdata
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOOKUP, ST_FETCH, ST_WRITE} wtc_st_t;

  typedef struct packed {
    wtc_st_t                            st;
    logic                               req_we;
    logic [wtc_pkg::ADDR_W-1:0]         req_addr;
    logic [wtc_pkg::BE_W-1:0]           req_be;
    logic [wtc_pkg::DATA_W-1:0]         req_wdata;
    logic                               req_cache;
    logic [wtc_pkg::LINE_IDX_W-1:0]     fill_line;
    logic [wtc_pkg::FA_IDX_W-1:0]       fill_fa;
    logic                               cpu_ready;
    logic                               cpu_hit;
    logic [wtc_pkg::DATA_W-1:0]         cpu_rdata;
    logic                               mem_req;
    logic                               mem_we;
    logic [wtc_pkg::ADDR_W-1:0]         mem_addr;
    logic [wtc_pkg::BE_W-1:0]           mem_be;
    logic [wtc_pkg::DATA_W-1:0]         mem_wdata;
  } wtc_state_t;

  wtc_state_t s_q;
  wtc_state_t s_d;

  // Line storage is kept apart from the control struct so that it is not copied each cycle.
  logic [wtc_pkg::DATA_W-1:0]     data_mem    [wtc_pkg::LINES];
  logic [wtc_pkg::TAG_W-1:0]      tag_mem     [wtc_pkg::LINES];
  logic [wtc_pkg::LINES-1:0]      valid_q;
  logic [wtc_pkg::SETS-1:0]       lru_q;
  logic [wtc_pkg::BLK_ADDR_W-1:0] fa_addr_mem [wtc_pkg::FA_ENTRIES];
  logic [wtc_pkg::DATA_W-1:0]     fa_data_mem [wtc_pkg::FA_ENTRIES];
  logic [wtc_pkg::FA_ENTRIES-1:0] fa_valid_q;

  logic                           full_mode;
  logic                           two_way;
  logic [wtc_pkg::SET_IDX_W-1:0]  set_idx;
  logic [wtc_pkg::LINE_IDX_W-1:0] line0;
  logic [wtc_pkg::LINE_IDX_W-1:0] line1;
  logic [wtc_pkg::TAG_W-1:0]      req_tag;
  logic [wtc_pkg::BLK_ADDR_W-1:0] req_blk;
  logic                           hit0;
  logic                           hit1;
  logic [wtc_pkg::FA_ENTRIES-1:0] fa_match;
  logic                           fa_hit;
  logic [wtc_pkg::FA_IDX_W-1:0]   fa_idx;
  logic                           hit;
  logic [wtc_pkg::DATA_W-1:0]     hit_data;
  logic                           victim_way;
  logic                           seq_way;
  logic                           rand_way;
  logic [wtc_pkg::FA_IDX_W-1:0]   fa_ptr;
  logic                           fill_en;
  logic                           fa_fill_en;
  logic                           wr_hit_en;
  logic [wtc_pkg::LINE_IDX_W-1:0] wr_line;
  logic                           lru_upd_en;
  logic                           lru_val;

  assign full_mode = (cfg_mode == wtc_pkg::MODE_FULL);
  assign two_way   = (cfg_mode == wtc_pkg::MODE_TWO_WAY);
  assign set_idx   = s_q.req_addr[wtc_pkg::SA_IDX_MSB:wtc_pkg::IDX_LSB];
  assign req_blk   = s_q.req_addr[wtc_pkg::ADDR_W-1:wtc_pkg::IDX_LSB];

  // Address split: direct mode uses a 14-bit index and 8-bit tag, two-way mode a 13-bit set.
  always_comb begin
    if (two_way) begin
      line0   = {1'b0, set_idx};
      line1   = {1'b1, set_idx};
      req_tag = s_q.req_addr[wtc_pkg::TAG_MSB:wtc_pkg::SA_TAG_LSB];
    end else begin
      line0   = s_q.req_addr[wtc_pkg::DM_IDX_MSB:wtc_pkg::IDX_LSB];
      line1   = line0;
      req_tag = {1'b0, s_q.req_addr[wtc_pkg::TAG_MSB:wtc_pkg::DM_TAG_LSB]};
    end
  end

  // Only tag bits are compared; the index is implied by the line read.
  assign hit0 = !full_mode && valid_q[line0] && (tag_mem[line0] == req_tag);
  assign hit1 = two_way && valid_q[line1] && (tag_mem[line1] == req_tag);

  // Every fully associative entry compares the whole block address.
  genvar gi;
  generate
    for (gi = 0; gi < wtc_pkg::FA_ENTRIES; gi++) begin : g_fa
      assign fa_match[gi] = fa_valid_q[gi] && (fa_addr_mem[gi] == req_blk);
    end
  endgenerate

  always_comb begin
    fa_idx = '0;
    for (int i = 0; i < wtc_pkg::FA_ENTRIES; i++) begin
      if (fa_match[i]) begin
        fa_idx = i[wtc_pkg::FA_IDX_W-1:0];
      end
    end
  end

  assign fa_hit = full_mode && (|fa_match);
  assign hit    = s_q.req_cache && (hit0 || hit1 || fa_hit);

  always_comb begin
    if (fa_hit) begin
      hit_data = fa_data_mem[fa_idx];
    end else if (hit1) begin
      hit_data = data_mem[line1];
    end else begin
      hit_data = data_mem[line0];
    end
  end

  // Victim way for a two-way refill follows the selected policy.
  always_comb begin
    unique case (cfg_policy)
      wtc_pkg::POL_SEQ:  victim_way = seq_way;
      wtc_pkg::POL_RAND: victim_way = rand_way;
      default:           victim_way = lru_q[set_idx];
    endcase
  end

  wtc_victim wtc_victim_inst (
    .clk      (clk),
    .rst      (rst),
    .adv      (fill_en || fa_fill_en),
    .seq_way  (seq_way),
    .rand_way (rand_way),
    .fa_ptr   (fa_ptr)
  );

  always_comb begin
    s_d        = s_q;
    s_d.cpu_ready = 1'b0;
    s_d.cpu_hit   = 1'b0;
    fill_en    = 1'b0;
    fa_fill_en = 1'b0;
    wr_hit_en  = 1'b0;
    wr_line    = hit1 ? line1 : line0;
    lru_upd_en = 1'b0;
    lru_val    = 1'b0;
    unique case (s_q.st)
      ST_IDLE: begin
        if (cpu_req) begin
          s_d.st        = ST_LOOKUP;
          s_d.req_we    = cpu_we;
          s_d.req_addr  = cpu_addr;
          s_d.req_be    = cpu_be;
          s_d.req_wdata = cpu_wdata;
          s_d.req_cache = (cpu_addr[wtc_pkg::ADDR_W-1:wtc_pkg::REGION_LSB] == CACHE_REGION);
        end
      end
      ST_LOOKUP: begin
        s_d.fill_line = (two_way && victim_way) ? line1 : line0;
        s_d.fill_fa   = fa_ptr;
        if (hit && two_way) begin
          lru_upd_en = 1'b1;
          lru_val    = !hit1;
        end
        if (s_q.req_we) begin
          wr_hit_en     = hit;
          s_d.cpu_hit   = 1'b0;
          s_d.st        = ST_WRITE;
          s_d.mem_req   = 1'b1;
          s_d.mem_we    = 1'b1;
          s_d.mem_addr  = s_q.req_addr;
          s_d.mem_be    = s_q.req_be;
          s_d.mem_wdata = s_q.req_wdata;
        end else if (hit) begin
          s_d.st        = ST_IDLE;
          s_d.cpu_ready = 1'b1;
          s_d.cpu_hit   = 1'b1;
          s_d.cpu_rdata = hit_data;
        end else begin
          s_d.st        = ST_FETCH;
          s_d.mem_req   = 1'b1;
          s_d.mem_we    = 1'b0;
          s_d.mem_addr  = {req_blk, wtc_pkg::OFS_ZERO};
          s_d.mem_be    = wtc_pkg::BE_ALL;
        end
      end
      ST_FETCH: begin
        if (mem_ack) begin
          fill_en       = s_q.req_cache && !full_mode;
          fa_fill_en    = s_q.req_cache && full_mode;
          s_d.st        = ST_IDLE;
          s_d.mem_req   = 1'b0;
          s_d.cpu_ready = 1'b1;
          s_d.cpu_rdata = mem_rdata;
          if (fill_en && two_way) begin
            lru_upd_en = 1'b1;
            lru_val    = !s_q.fill_line[wtc_pkg::SET_IDX_W];
          end
        end
      end
      ST_WRITE: begin
        if (mem_ack) begin
          s_d.st        = ST_IDLE;
          s_d.mem_req   = 1'b0;
          s_d.mem_we    = 1'b0;
          s_d.cpu_ready = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{st: ST_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Valid and usage bits are reset; data and tag contents are not.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_q    <= '0;
      fa_valid_q <= '0;
      lru_q      <= '0;
    end else begin
      if (fill_en) begin
        valid_q[s_q.fill_line] <= 1'b1;
      end
      if (fa_fill_en) begin
        fa_valid_q[s_q.fill_fa] <= 1'b1;
      end
      if (lru_upd_en) begin
        lru_q[set_idx] <= lru_val;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (fill_en) begin
      data_mem[s_q.fill_line] <= mem_rdata;
      tag_mem[s_q.fill_line]  <= req_tag;
    end
    if (fa_fill_en) begin
      fa_data_mem[s_q.fill_fa] <= mem_rdata;
      fa_addr_mem[s_q.fill_fa] <= req_blk;
    end
    for (int b = 0; b < wtc_pkg::BE_W; b++) begin
      if (wr_hit_en && s_q.req_be[b]) begin
        if (fa_hit) begin
          fa_data_mem[fa_idx][b*8 +: 8] <= s_q.req_wdata[b*8 +: 8];
        end else begin
          data_mem[wr_line][b*8 +: 8] <= s_q.req_wdata[b*8 +: 8];
        end
      end
    end
  end

  assign cpu_ready = s_q.cpu_ready;
  assign cpu_hit   = s_q.cpu_hit;
  assign cpu_rdata = s_q.cpu_rdata;
  assign mem_req   = s_q.mem_req;
  assign mem_we    = s_q.mem_we;
  assign mem_addr  = s_q.mem_addr;
  assign mem_be    = s_q.mem_be;
  assign mem_wdata = s_q.mem_wdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rd_hit_a: assert property ((s_q.st == ST_LOOKUP) && !s_q.req_we && hit
    |=> cpu_ready && cpu_hit && !mem_req) else $error("read hit not served from cache");
  rd_miss_a: assert property ((s_q.st == ST_LOOKUP) && !s_q.req_we && !hit
    |=> mem_req && !mem_we && (mem_be == wtc_pkg::BE_ALL)
        && (mem_addr[wtc_pkg::OFS_W-1:0] == wtc_pkg::OFS_ZERO))
    else $error("miss did not fetch aligned block");
  wr_thru_a: assert property ((s_q.st == ST_LOOKUP) && s_q.req_we
    |=> mem_req && mem_we && (mem_addr == $past(s_q.req_addr))) else $error("write not forwarded");
  fill_tag_a: assert property (fill_en
    |=> valid_q[$past(s_q.fill_line)] && (tag_mem[$past(s_q.fill_line)] == $past(req_tag)))
    else $error("fill did not set tag and valid");
  no_alloc_a: assert property ((s_q.st == ST_WRITE) |-> !fill_en && !fa_fill_en)
    else $error("write miss allocated a line");
  dm_single_a: assert property (!two_way |-> !hit1) else $error("second compare in direct mode");
  one_way_a: assert property ((s_q.st == ST_LOOKUP) |-> !(hit0 && hit1))
    else $error("both ways hit");
  fa_onehot_a: assert property ($onehot0(fa_match)) else $error("duplicate block address");
  lru_upd_a: assert property ((s_q.st == ST_LOOKUP) && two_way && hit && hit1
    |=> lru_q[$past(set_idx)] == 1'b0) else $error("usage bit not updated on hit");
  uncached_a: assert property ((s_q.st == ST_FETCH) && !s_q.req_cache |-> !fill_en)
    else $error("uncached access filled a line");
  no_copyback_a: assert property (fill_en |-> !mem_we) else $error("refill copied back");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped before ack");

  rd_hit_c: cover property ((s_q.st == ST_LOOKUP) && !s_q.req_we && hit);
  rd_fill_c: cover property (fill_en ##1 (s_q.st == ST_IDLE));
  wr_hit_c: cover property (wr_hit_en);
  way1_hit_c: cover property ((s_q.st == ST_LOOKUP) && hit1);
endmodule // wtc_cache
`default_nettype wire

// *** wtc_pkg.sv ***
// Constants, field positions and encodings shared by the write-through cache controller.
// Assumes one 100 MHz clock domain and a processor that holds mode inputs static after reset.
package wtc_pkg;
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned BE_W       = 4;
  localparam int unsigned OFS_W      = 2;
  localparam int unsigned LINE_IDX_W = 14;
  localparam int unsigned SET_IDX_W  = 13;
  localparam int unsigned DM_TAG_W   = 8;
  localparam int unsigned TAG_W      = 9;
  localparam int unsigned REGION_W   = 8;
  localparam int unsigned BLK_ADDR_W = 30;
  localparam int unsigned LINES      = 16384;
  localparam int unsigned SETS       = 8192;
  localparam int unsigned FA_ENTRIES = 128;
  localparam int unsigned FA_IDX_W   = 7;
  localparam int unsigned LFSR_W     = 16;

  localparam int unsigned IDX_LSB    = 2;
  localparam int unsigned DM_IDX_MSB = 15;
  localparam int unsigned SA_IDX_MSB = 14;
  localparam int unsigned DM_TAG_LSB = 16;
  localparam int unsigned SA_TAG_LSB = 15;
  localparam int unsigned TAG_MSB    = 23;
  localparam int unsigned REGION_LSB = 24;

  localparam logic [1:0] MODE_DIRECT  = 2'h0;
  localparam logic [1:0] MODE_TWO_WAY = 2'h1;
  localparam logic [1:0] MODE_FULL    = 2'h2;

  localparam logic [1:0] POL_LRU  = 2'h0;
  localparam logic [1:0] POL_SEQ  = 2'h1;
  localparam logic [1:0] POL_RAND = 2'h2;

  localparam logic [BE_W-1:0]   BE_ALL      = 4'hF;
  localparam logic [OFS_W-1:0]  OFS_ZERO    = 2'h0;
  localparam logic [LFSR_W-1:0] LFSR_SEED   = 16'hACE1;
  localparam logic [LFSR_W-1:0] LFSR_TAPS   = 16'hB400;
  localparam logic [REGION_W-1:0] REGION_DEF = 8'h00;
endpackage

// *** wtc_victim.sv ***
// Victim choosers for set-associative and fully associative refills.
// Assumes adv pulses once per block fetch that fills the cache.
`timescale 1ns/100ps
`default_nettype none
module wtc_victim (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        adv,
  output logic                             seq_way,
  output logic                             rand_way,
  output logic [wtc_pkg::FA_IDX_W-1:0]     fa_ptr
);
  typedef struct packed {
    logic                          seq;
    logic [wtc_pkg::LFSR_W-1:0]    lfsr;
    logic [wtc_pkg::FA_IDX_W-1:0]  ptr;
  } wtc_vic_t;

  wtc_vic_t s_q;
  wtc_vic_t s_d;

  // Sequential order rotates the way, random order steps a Galois LFSR.
  always_comb begin
    s_d = s_q;
    if (adv) begin
      s_d.seq = ~s_q.seq;
      s_d.ptr = s_q.ptr + 1'b1;
      if (s_q.lfsr[0]) begin
        s_d.lfsr = (s_q.lfsr >> 1) ^ wtc_pkg::LFSR_TAPS;
      end else begin
        s_d.lfsr = s_q.lfsr >> 1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q.seq  <= 1'b0;
      s_q.lfsr <= wtc_pkg::LFSR_SEED;
      s_q.ptr  <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign seq_way  = s_q.seq;
  assign rand_way = s_q.lfsr[0];
  assign fa_ptr   = s_q.ptr;
endmodule // wtc_victim
`default_nettype wire

// *** wtc_mem.sv ***
// Behavioural main memory that answers the cache controller's memory port.
// Assumes the controller's clock and an answer delay chosen by the bench.
`timescale 1ns/100ps
`default_nettype none
module wtc_mem (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  delay,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  mem_be,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  output logic [15:0]      rd_cnt,
  output logic [15:0]      wr_cnt
);
  logic [31:0] store [logic [29:0]];
  logic [31:0] last_addr;
  logic [3:0]  last_be;
  logic [31:0] last_wdata;
  int          wait_n;

  // Unwritten words read back a pattern made from their address.
  function automatic logic [31:0] word(input logic [31:0] a);
    if (store.exists(a[31:2])) return store[a[31:2]];
    return {a[31:2], 2'b00} ^ 32'hC3A50F96;
  endfunction

  always @(posedge clk or posedge rst) begin : answer
    logic        s_req;
    logic        s_we;
    logic [31:0] s_addr;
    logic [3:0]  s_be;
    logic [31:0] s_wd;
    logic [31:0] w;
    if (rst) begin
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
      rd_cnt = 16'h0;
      wr_cnt = 16'h0;
      wait_n = 0;
    end else begin
      s_req = mem_req;
      s_we = mem_we;
      s_addr = mem_addr;
      s_be = mem_be;
      s_wd = mem_wdata;
      #1;
      // Data lines outside an answer change every cycle.
      mem_rdata = ~mem_rdata;
      if (mem_ack) begin
        mem_ack = 1'b0;
      end else if (s_req && wait_n < delay) begin
        wait_n++;
      end else if (s_req) begin
        wait_n = 0;
        mem_ack = 1'b1;
        last_addr = s_addr;
        last_be = s_be;
        last_wdata = s_wd;
        if (s_we) begin
          w = word(s_addr);
          for (int k = 0; k < 4; k++) begin
            if (s_be[k]) w[8*k+:8] = s_wd[8*k+:8];
          end
          store[s_addr[31:2]] = w;
          wr_cnt++;
        end else begin
          mem_rdata = word(s_addr);
          rd_cnt++;
        end
      end
    end
  end
endmodule // wtc_mem
`default_nettype wire

// *** test_write_through_cache_controller.sv ***
// Self-checking bench for the write-through cache controller with a memory model behind it.
// Assumes one outstanding request at a time, each completed by a one-cycle ready.
`timescale 1ns/100ps
`default_nettype none
module test_write_through_cache_controller;
  typedef struct packed {
    logic [1:0]  mode;
    logic [1:0]  pol;
    logic        we;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] wd;
    logic [1:0]  hit;
  } wtc_tb_row_t;

  localparam logic [1:0]  DM   = wtc_pkg::MODE_DIRECT;
  localparam logic [1:0]  TW   = wtc_pkg::MODE_TWO_WAY;
  localparam logic [1:0]  FA   = wtc_pkg::MODE_FULL;
  localparam logic [1:0]  LRU  = wtc_pkg::POL_LRU;
  localparam logic [1:0]  SEQ  = wtc_pkg::POL_SEQ;
  localparam logic [1:0]  RND  = wtc_pkg::POL_RAND;
  localparam logic [1:0]  MISS = 2'h0;
  localparam logic [1:0]  HIT  = 2'h1;
  localparam logic [1:0]  ANY  = 2'h2;
  localparam logic        R    = 1'b0;
  localparam logic        W    = 1'b1;
  localparam logic [3:0]  F    = 4'hF;
  localparam logic [31:0] Z    = 32'h0;
  localparam int          NROWS = 31;

  logic        clk;
  logic        rst;
  logic [1:0]  cfg_mode;
  logic [1:0]  cfg_policy;
  logic        cpu_req;
  logic        cpu_we;
  logic [31:0] cpu_addr;
  logic [3:0]  cpu_be;
  logic [31:0] cpu_wdata;
  logic        cpu_ready;
  logic        cpu_hit;
  logic [31:0] cpu_rdata;
  logic        mem_req;
  logic        mem_we;
  logic [31:0] mem_addr;
  logic [3:0]  mem_be;
  logic [31:0] mem_wdata;
  logic        mem_ack;
  logic [31:0] mem_rdata;
  logic [3:0]  mem_delay;
  logic [15:0] rd_cnt;
  logic [15:0] wr_cnt;
  logic [1:0]  cur_mode;
  logic [1:0]  cur_pol;
  int          fails;
  int          cmp_count;
  wtc_tb_row_t fr;

  wtc_tb_row_t rows [0:NROWS-1] = '{
    '{DM, LRU, R, 32'h0012FFE9, F, Z, MISS},
    '{DM, LRU, R, 32'h0012FFEB, F, Z, HIT},
    '{DM, LRU, R, 32'h0044FFE8, F, Z, MISS},
    '{DM, LRU, R, 32'h0012FFE8, F, Z, MISS},
    '{DM, LRU, W, 32'h0012FFEA, 4'h4, 32'hA1B2C3D4, HIT},
    '{DM, LRU, R, 32'h0012FFE8, F, Z, HIT},
    '{DM, LRU, W, 32'h00550000, F, 32'h13572468, MISS},
    '{DM, LRU, R, 32'h00550000, F, Z, MISS},
    '{DM, LRU, R, 32'h0112FFE8, F, Z, MISS},
    '{DM, LRU, R, 32'h0112FFE8, F, Z, MISS},
    '{DM, LRU, R, 32'h0012FFE8, F, Z, HIT},
    '{DM, LRU, R, 32'h0012FFEC, F, Z, MISS},
    '{TW, LRU, R, 32'h00127FE8, F, Z, MISS},
    '{TW, LRU, R, 32'h0012FFE8, F, Z, MISS},
    '{TW, LRU, R, 32'h00127FE8, F, Z, HIT},
    '{TW, LRU, R, 32'h0012FFE8, F, Z, HIT},
    '{TW, LRU, R, 32'h0044FFE8, F, Z, MISS},
    '{TW, LRU, R, 32'h0012FFE8, F, Z, HIT},
    '{TW, LRU, R, 32'h00127FE8, F, Z, MISS},
    '{TW, LRU, W, 32'h0012FFE9, 4'h2, 32'h5A6B7C8D, HIT},
    '{TW, LRU, R, 32'h0012FFE8, F, Z, HIT},
    '{TW, SEQ, R, 32'h0012FFE8, F, Z, MISS},
    '{TW, SEQ, R, 32'h0044FFE8, F, Z, MISS},
    '{TW, SEQ, R, 32'h0012FFE8, F, Z, HIT},
    '{TW, SEQ, R, 32'h0066FFE8, F, Z, MISS},
    '{TW, SEQ, R, 32'h0044FFE8, F, Z, HIT},
    '{TW, RND, R, 32'h0012FFE8, F, Z, MISS},
    '{TW, RND, R, 32'h0044FFE8, F, Z, MISS},
    '{TW, RND, R, 32'h0066FFE8, F, Z, MISS},
    '{TW, RND, R, 32'h0066FFE8, F, Z, HIT},
    '{DM, LRU, R, 32'h0012FFE8, F, Z, MISS}
  };

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  wtc_cache #(.CACHE_REGION(8'h00)) wtc_cache_inst (
    .clk(clk), .rst(rst), .cfg_mode(cfg_mode), .cfg_policy(cfg_policy),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_be(cpu_be),
    .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready), .cpu_hit(cpu_hit), .cpu_rdata(cpu_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  wtc_mem wtc_mem_inst (
    .clk(clk), .rst(rst), .delay(mem_delay), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .rd_cnt(rd_cnt), .wr_cnt(wr_cnt));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] mode, input logic [1:0] pol);
    rst = 1'b1;
    cfg_mode = mode;
    cfg_policy = pol;
    cur_mode = mode;
    cur_pol = pol;
    repeat (6) @(posedge clk);
    check("outputs in reset", {29'h0, cpu_ready, cpu_hit, mem_req}, Z);
    #1 rst = 1'b0;
  endtask

  task automatic access(input wtc_tb_row_t r, output logic hit_seen, output logic [31:0] rd,
                        output int lat);
    @(posedge clk);
    #1;
    cpu_req = 1'b1;
    cpu_we = r.we;
    cpu_addr = r.addr;
    cpu_be = r.be;
    cpu_wdata = r.wd;
    @(posedge clk);
    #1;
    cpu_req = 1'b0;
    lat = 0;
    while (cpu_ready !== 1'b1 && lat < 200) begin
      @(posedge clk);
      #1;
      lat++;
    end
    check("cpu_ready", {31'h0, cpu_ready}, 32'h1);
    hit_seen = cpu_hit;
    rd = cpu_rdata;
  endtask

  task automatic run_row(input wtc_tb_row_t r);
    logic        hit_seen;
    logic [31:0] rd;
    int          lat;
    logic [15:0] r0;
    logic [15:0] w0;
    if (r.mode !== cur_mode || r.pol !== cur_pol) do_reset(r.mode, r.pol);
    r0 = rd_cnt;
    w0 = wr_cnt;
    access(r, hit_seen, rd, lat);
    if (r.hit != ANY) check("cpu_hit", {31'h0, hit_seen}, {31'h0, r.hit == HIT && !r.we});
    if (!r.we) check("cpu_rdata", rd, wtc_mem_inst.word(r.addr));
    if (r.we) begin
      check("fetches on write", {16'h0, rd_cnt - r0}, Z);
      check("memory writes", {16'h0, wr_cnt - w0}, 32'h1);
      check("write address", wtc_mem_inst.last_addr, r.addr);
      check("write lanes", {28'h0, wtc_mem_inst.last_be}, {28'h0, r.be});
      check("write data", wtc_mem_inst.last_wdata, r.wd);
    end else if (r.hit == HIT) begin
      check("fetches on hit", {16'h0, rd_cnt - r0}, Z);
      check("hit latency", lat, 32'h1);
    end else if (r.hit == MISS) begin
      check("fetches on miss", {16'h0, rd_cnt - r0}, 32'h1);
      check("fetch address", wtc_mem_inst.last_addr, {r.addr[31:2], 2'b00});
      check("fetch lanes", {28'h0, wtc_mem_inst.last_be}, 32'hF);
    end
  endtask

  initial begin
    #400000;
    fails++;
    $display("[FAIL] watchdog expected completion seen timeout");
    complete_run();
  end

  initial begin
    rst = 1'b1;
    cfg_mode = DM;
    cfg_policy = LRU;
    cpu_req = 1'b0;
    cpu_we = 1'b0;
    cpu_addr = Z;
    cpu_be = 4'h0;
    cpu_wdata = Z;
    mem_delay = 4'h0;
    fails = 0;
    cmp_count = 0;
    cur_mode = 2'h3;
    cur_pol = 2'h3;
    for (int i = 0; i < NROWS; i++) begin
      mem_delay = 4'(i % 3);
      run_row(rows[i]);
    end
    // Fully associative: fill all entries, reread them, then overflow by one.
    mem_delay = 4'h1;
    fr = '{FA, LRU, R, 32'h0000FFE8, F, Z, MISS};
    for (int i = 0; i < 256; i++) begin
      fr.addr = 32'h0000FFE8 | ((i % 128) << 16);
      fr.hit = (i < 128) ? MISS : HIT;
      run_row(fr);
    end
    fr.addr = 32'h0080FFE8;
    fr.hit = MISS;
    run_row(fr);
    fr.addr = 32'h0001FFE8;
    fr.hit = HIT;
    run_row(fr);
    fr.addr = 32'h0000FFE8;
    fr.hit = MISS;
    run_row(fr);
    fr.we = W;
    fr.addr = 32'h0002FFE9;
    fr.be = 4'h2;
    fr.wd = 32'h24681357;
    fr.hit = HIT;
    run_row(fr);
    fr.we = R;
    fr.addr = 32'h0002FFE8;
    fr.be = F;
    run_row(fr);
    complete_run();
  end
endmodule // test_write_through_cache_controller
`default_nettype wire
